/* pwrflt_pkg.sv */
package pwrflt_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TEMP_W        = 8;
  localparam int unsigned SYNC_W        = 14;
  // Temperatures in degrees Celsius
  localparam logic [7:0]  TEMP_WARN_C   = 8'h7d;
  localparam logic [7:0]  TEMP_ERR_C    = 8'h9b;
  localparam logic [7:0]  TEMP_HYST_C   = 8'h19;
  // Sync stage reset: resets asserted, supplies reported low
  localparam logic [13:0] SYNC_RST      = 14'h0c00;
  localparam int unsigned SYNC_RST1_BIT = 8;
  localparam int unsigned SYNC_RST2_BIT = 9;
  localparam int unsigned SYNC_GUV_BIT  = 10;
  localparam int unsigned SYNC_CUV_BIT  = 11;
  localparam int unsigned SYNC_OL_LSB   = 12;

  // Overload recovery wait
  localparam int unsigned OLP_WAIT_MS   = 1000;
  localparam int unsigned OLP_WAIT_CYC  = CLK_HZ / 1000 * OLP_WAIT_MS;
  localparam int unsigned CNT_W         = 25;
  // Recovery reset pulse, in microseconds
  localparam int unsigned RST_PULSE_US  = 1;
  localparam int unsigned RST_PULSE_CYC = CLK_HZ / 1_000_000 * RST_PULSE_US;

  // Host register map (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_EVENTS    = 8'h08;
  localparam int unsigned CTRL_REL1_BIT = 0;
  localparam int unsigned CTRL_REL2_BIT = 1;
  localparam int unsigned CTRL_AUTO_BIT = 2;
  localparam logic [2:0]  CTRL_RST      = 3'h0;
  localparam int unsigned EVT_SD_BIT    = 0;
  localparam int unsigned EVT_OTW_BIT   = 1;
  localparam logic [1:0]  EVT_RST       = 2'h0;

  typedef enum logic [1:0] {
    PWRFLT_RUN   = 2'b00,
    PWRFLT_WAIT  = 2'b01,
    PWRFLT_READY = 2'b10,
    PWRFLT_PULSE = 2'b11
  } pwrflt_state_e;

endpackage

/* pwrflt_if.sv */
interface pwrflt_if;
  logic reset_pair_first_n;
  logic reset_pair_second_n;
  logic sd_o;
  logic sd_oe;
  logic otw_o;
  logic otw_oe;
  logic shutdown_flag_n;
  logic overtemp_warning_n;

  // Open-drain wires with pull-ups: low only while driven low
  assign shutdown_flag_n    = !(sd_oe && !sd_o);
  assign overtemp_warning_n = !(otw_oe && !otw_o);

  modport dev (
    input  reset_pair_first_n,
    input  reset_pair_second_n,
    output sd_o,
    output sd_oe,
    output otw_o,
    output otw_oe,
    input  shutdown_flag_n,
    input  overtemp_warning_n
  );

  modport host (
    output reset_pair_first_n,
    output reset_pair_second_n,
    input  shutdown_flag_n,
    input  overtemp_warning_n
  );
endinterface

/* pwrflt_dev.sv */
module pwrflt_dev (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  pwrflt_if.dev           link,
  input  wire logic       gate_drive_uv,
  input  wire logic       common_uv,
  input  wire logic [7:0] junction_temp_c,
  input  wire logic [1:0] overload_det,
  input  wire logic       se_mode,
  output logic      [3:0] hb_hiz,
  output logic      [3:0] hb_pulldown,
  output logic            overtemp_error,
  output logic      [1:0] overload_fault
);

  logic [13:0] raw;
  logic [13:0] s1_q;
  logic [13:0] s2_q;
  logic [7:0]  temp_prev_q;
  logic [7:0]  temp_q;
  logic [7:0]  temp_d;
  logic [1:0]  rst_prev_q;
  logic        ote_q;
  logic        ote_d;
  logic [1:0]  ol_q;
  logic [1:0]  ol_d;
  logic [3:0]  hiz_q;
  logic [3:0]  hiz_d;
  logic [3:0]  pd_q;
  logic [3:0]  pd_d;
  logic        sd_oe_q;
  logic        sd_oe_d;
  logic        otw_oe_q;
  logic        otw_oe_d;
  logic        flag_lvl_q;

  wire [7:0] temp_s   = s2_q[7:0];
  wire [1:0] rst_s    = {s2_q[pwrflt_pkg::SYNC_RST2_BIT],
                         s2_q[pwrflt_pkg::SYNC_RST1_BIT]};
  wire       guv_s    = s2_q[pwrflt_pkg::SYNC_GUV_BIT];
  wire       cuv_s    = s2_q[pwrflt_pkg::SYNC_CUV_BIT];
  wire [1:0] ovl_s    = s2_q[pwrflt_pkg::SYNC_OL_LSB +: 2];

  assign raw = {overload_det, common_uv, gate_drive_uv,
                link.reset_pair_second_n, link.reset_pair_first_n,
                junction_temp_c};

  genvar gi;
  generate
    for (gi = 0; gi < pwrflt_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          s1_q[gi] <= pwrflt_pkg::SYNC_RST[gi];
          s2_q[gi] <= pwrflt_pkg::SYNC_RST[gi];
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  // Temperature word taken only when two samples agree
  // Bits of a changing word may land in different cycles
  assign temp_d = (temp_s == temp_prev_q) ? temp_s : temp_q;

  wire supply_ok  = !guv_s && !cuv_s;
  wire warn_hot   = temp_q > pwrflt_pkg::TEMP_WARN_C;
  wire err_hot    = temp_q > pwrflt_pkg::TEMP_ERR_C;
  wire err_cool   = temp_q <= (pwrflt_pkg::TEMP_ERR_C -
                               pwrflt_pkg::TEMP_HYST_C);
  wire both_rst   = !rst_s[0] && !rst_s[1];
  wire any_rst    = !rst_s[0] || !rst_s[1];
  wire [1:0] rise = rst_s & ~rst_prev_q;
  wire any_rise   = |rise;

  // Error latch, clear needs both resets and cooling
  // A new over-temperature in the clearing cycle keeps it set
  assign ote_d = err_hot ? 1'b1 :
                 (both_rst && err_cool) ? 1'b0 : ote_q;

  // Per-pair overload latch
  // Supply loss also clears it, ahead of detection; detection wins over a reset-rise clear
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ol
      assign ol_d[gi] = !supply_ok ? 1'b0 :
                        ovl_s[gi] ? 1'b1 :
                        any_rise ? 1'b0 : ol_q[gi];
    end
  endgenerate

  wire fault_d = !supply_ok || ote_d || (|ol_d);

  // Shutdown flag driven low on fault unless reset
  assign sd_oe_d  = fault_d && !any_rst;
  // Warning low when hot, and with a latched error
  assign otw_oe_d = warn_hot || ote_d;

  generate
    for (gi = 0; gi < 4; gi++) begin : g_hb
      assign hiz_d[gi] = !supply_ok || ote_d || ol_d[gi / 2] ||
                         !rst_s[gi / 2];
      assign pd_d[gi]  = !rst_s[gi / 2] && !se_mode;
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      temp_prev_q <= 8'h00;
      temp_q      <= 8'h00;
      rst_prev_q  <= 2'h0;
      ote_q       <= 1'b0;
      ol_q        <= 2'h0;
    end else begin
      temp_prev_q <= temp_s;
      temp_q      <= temp_d;
      rst_prev_q  <= rst_s;
      ote_q       <= ote_d;
      ol_q        <= ol_d;
    end
  end

  // Outputs start safe: all bridges Hi-Z, flags released
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hiz_q      <= 4'hf;
      pd_q       <= 4'h0;
      sd_oe_q    <= 1'b0;
      otw_oe_q   <= 1'b0;
      flag_lvl_q <= 1'b0;
    end else begin
      hiz_q      <= hiz_d;
      pd_q       <= pd_d;
      sd_oe_q    <= sd_oe_d;
      otw_oe_q   <= otw_oe_d;
      flag_lvl_q <= 1'b0;
    end
  end

  // Open drain: data is always low, only enable moves
  assign link.sd_o     = flag_lvl_q;
  assign link.otw_o    = flag_lvl_q;
  assign link.sd_oe    = sd_oe_q;
  assign link.otw_oe   = otw_oe_q;
  assign hb_hiz        = hiz_q;
  assign hb_pulldown   = pd_q;
  assign overtemp_error = ote_q;
  assign overload_fault = ol_q;

endmodule

/* pwrflt_host.sv */
module pwrflt_host #(
  parameter int unsigned WAIT_CYCLES = pwrflt_pkg::OLP_WAIT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  pwrflt_if.host           link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  pwrflt_pkg::pwrflt_state_e st_q;
  pwrflt_pkg::pwrflt_state_e st_d;
  logic [2:0]  ctrl_q;
  logic [1:0]  evt_q;
  logic [1:0]  evt_d;
  logic [24:0] cnt_q;
  logic [24:0] cnt_d;
  logic [1:0]  rst_q;
  logic [1:0]  rst_d;
  logic        sd_prev_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  wire sd_n     = link.shutdown_flag_n;
  wire otw_n    = link.overtemp_warning_n;
  wire sd_fall  = sd_prev_q && !sd_n;
  wire setup    = psel && !penable;
  wire access   = psel && penable && pready_q;
  wire wr       = access && pwrite;
  wire hit_ctrl = paddr == pwrflt_pkg::REG_CTRL;
  wire hit_stat = paddr == pwrflt_pkg::REG_STATUS;
  wire hit_evt  = paddr == pwrflt_pkg::REG_EVENTS;
  wire mapped   = hit_ctrl || hit_stat || hit_evt;
  wire cnt_end  = cnt_q == 25'(WAIT_CYCLES - 1);
  wire pls_end  = cnt_q == 25'(pwrflt_pkg::RST_PULSE_CYC - 1);
  wire auto_en  = ctrl_q[pwrflt_pkg::CTRL_AUTO_BIT];
  wire [1:0] rel = {ctrl_q[pwrflt_pkg::CTRL_REL2_BIT],
                    ctrl_q[pwrflt_pkg::CTRL_REL1_BIT]};

  wire [31:0] stat_word = {26'h0, rst_q, st_q, otw_n, sd_n};
  wire [31:0] rd_word   = hit_ctrl ? {29'h0, ctrl_q} :
                          hit_stat ? stat_word :
                          hit_evt  ? {30'h0, evt_q} : 32'h0;

  // Sticky event bits, write one to clear, set wins
  assign evt_d = {!otw_n, sd_fall} |
                 (evt_q & ~((wr && hit_evt) ? pwdata[1:0] : 2'h0));

  // Recovery waits a full second after shutdown
  always_comb begin
    st_d  = st_q;
    cnt_d = 25'h0;
    rst_d = rst_q;
    case (st_q)
      pwrflt_pkg::PWRFLT_RUN: begin
        rst_d = rel;
        if (sd_fall) st_d = pwrflt_pkg::PWRFLT_WAIT;
      end
      pwrflt_pkg::PWRFLT_WAIT: begin
        cnt_d = cnt_q + 25'h1;
        if (cnt_end) begin
          cnt_d = 25'h0;
          st_d  = auto_en ? pwrflt_pkg::PWRFLT_PULSE :
                            pwrflt_pkg::PWRFLT_READY;
        end
      end
      pwrflt_pkg::PWRFLT_READY: begin
        if (sd_n) st_d = pwrflt_pkg::PWRFLT_RUN;
      end
      pwrflt_pkg::PWRFLT_PULSE: begin
        // Both resets low clears an error latch too, once the temperature has cooled
        rst_d = 2'h0;
        cnt_d = cnt_q + 25'h1;
        if (pls_end) st_d = pwrflt_pkg::PWRFLT_RUN;
      end
      default: begin
        st_d = pwrflt_pkg::PWRFLT_RUN;
      end
    endcase
  end

  // Resets held low from reset until software releases
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q      <= pwrflt_pkg::PWRFLT_RUN;
      cnt_q     <= 25'h0;
      rst_q     <= 2'h0;
      sd_prev_q <= 1'b1;
      evt_q     <= pwrflt_pkg::EVT_RST;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      rst_q     <= rst_d;
      sd_prev_q <= sd_n;
      evt_q     <= evt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_q    <= pwrflt_pkg::CTRL_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      if (wr && hit_ctrl) ctrl_q <= pwdata[2:0];
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= setup ? rd_word : 32'h0;
    end
  end

  assign link.reset_pair_first_n  = rst_q[0];
  assign link.reset_pair_second_n = rst_q[1];
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

endmodule

/* pwrflt_monitor.sv */
module pwrflt_monitor #(
  parameter int unsigned WAIT_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic reset_pair_first_n,
  input wire logic reset_pair_second_n,
  input wire logic sd_o,
  input wire logic sd_oe,
  input wire logic otw_o,
  input wire logic otw_oe,
  input wire logic shutdown_flag_n,
  input wire logic overtemp_warning_n
);
  int unsigned frz_q;

  // Host hold-off window opened by a shutdown report; entry lag only
  // lengthens the real window, so this count never outruns it
  always_ff @(posedge sys_clk) begin
    if (srst || frz_q >= WAIT_CYCLES - 1) begin
      frz_q <= 0;
    end else if (frz_q != 0 || $fell(shutdown_flag_n)) begin
      frz_q <= frz_q + 1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  AST_SD_DRIVE_LOW: assert property (sd_oe |-> !sd_o)
    else $error("shutdown flag driven high");
  AST_OTW_DRIVE_LOW: assert property (otw_oe |-> !otw_o)
    else $error("warning flag driven high");
  AST_SD_WIRE: assert property (shutdown_flag_n == !sd_oe)
    else $error("shutdown wire level wrong");
  AST_OTW_WIRE: assert property (overtemp_warning_n == !otw_oe)
    else $error("warning wire level wrong");
  AST_RST1_SD: assert property ((!reset_pair_first_n)[*5] |-> !sd_oe)
    else $error("shutdown shown with first reset low");
  AST_RST2_SD: assert property ((!reset_pair_second_n)[*5] |-> !sd_oe)
    else $error("shutdown shown with second reset low");
  AST_HOLD_OFF: assert property (frz_q != 0 |->
    $stable(reset_pair_first_n) && $stable(reset_pair_second_n))
    else $error("reset moved inside hold-off window");
  AST_START_LOW: assert property ($fell(srst) |->
    !reset_pair_first_n && !reset_pair_second_n)
    else $error("resets not held low at start");

  COV_SD: cover property ($fell(shutdown_flag_n));
  COV_OTW: cover property ($fell(overtemp_warning_n));
  COV_HOLD: cover property (frz_q == WAIT_CYCLES - 1);
endmodule

/* power_stage_fault_reporting_tb.sv */
module power_stage_fault_reporting_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned WAITC = 50;
  localparam logic [32:0] MS    = 33'h1_0000_003f;
  localparam logic [32:0] MD    = 33'h7ff;
  logic        sys_clk;
  logic        srst            = 1'b1;
  logic        gate_drive_uv   = 1'b1;
  logic        common_uv       = 1'b1;
  logic [7:0]  junction_temp_c = 8'h19;
  logic [1:0]  overload_det    = 2'h0;
  logic        se_mode         = 1'b0;
  logic        psel            = 1'b0;
  logic        penable         = 1'b0;
  logic        pwrite          = 1'b0;
  logic [7:0]  paddr           = 8'h00;
  logic [31:0] pwdata          = 32'h0;
  logic        snap            = 1'b0;
  logic [3:0]  hb_hiz;
  logic [3:0]  hb_pulldown;
  logic        overtemp_error;
  logic [1:0]  overload_fault;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_total       = 0;
  int          check_count     = 0;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  string       nm_q[$];
  wire  [32:0] obs = snap ? {22'h0, hb_pulldown, hb_hiz, overload_fault,
                             overtemp_error} : {pslverr, prdata};

  pwrflt_if link_if ();

  pwrflt_dev pwrflt_dev_i (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .link            (link_if),
    .gate_drive_uv   (gate_drive_uv),
    .common_uv       (common_uv),
    .junction_temp_c (junction_temp_c),
    .overload_det    (overload_det),
    .se_mode         (se_mode),
    .hb_hiz          (hb_hiz),
    .hb_pulldown     (hb_pulldown),
    .overtemp_error  (overtemp_error),
    .overload_fault  (overload_fault)
  );

  pwrflt_host #(.WAIT_CYCLES(WAITC)) pwrflt_host_i (
    .sys_clk (sys_clk),
    .srst    (srst),
    .link    (link_if),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  pwrflt_monitor #(.WAIT_CYCLES(WAITC)) pwrflt_monitor_i (
    .sys_clk             (sys_clk),
    .srst                (srst),
    .reset_pair_first_n  (link_if.reset_pair_first_n),
    .reset_pair_second_n (link_if.reset_pair_second_n),
    .sd_o                (link_if.sd_o),
    .sd_oe               (link_if.sd_oe),
    .otw_o               (link_if.otw_o),
    .otw_oe              (link_if.otw_oe),
    .shutdown_flag_n     (link_if.shutdown_flag_n),
    .overtemp_warning_n  (link_if.overtemp_warning_n)
  );

  function automatic logic [32:0] dw(input logic [3:0] p,
    input logic [3:0] h, input logic [1:0] o, input logic e);
    return {22'h0, p, h, o, e};
  endfunction

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Waits for the slave however long it takes; the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
    input logic [32:0] m, input string s);
    exp_q.push_back(e);
    msk_q.push_back(m);
    nm_q.push_back(s);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic snap_dev(input logic [32:0] e, input string s);
    exp_q.push_back(e);
    msk_q.push_back(MD);
    nm_q.push_back(s);
    snap <= 1'b1;
    @(posedge sys_clk);
    snap <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Oldest note pairs with whichever result shows first
  always @(posedge sys_clk) begin
    if (snap || (psel && penable && pready && !pwrite)) begin
      check_count++;
      if ((obs & msk_q[0]) !== exp_q[0]) begin
        err_total++;
        $display("[FAIL] %s expected %h seen %h", nm_q[0], exp_q[0],
                 obs & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(nm_q.pop_front());
    end
  end

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    void'($urandom(72));
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'hf, 4'hf, 2'h0, 1'b0), "power up");
    gate_drive_uv <= 1'b0;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'hf, 4'hf, 2'h0, 1'b0), "one supply");
    common_uv <= 1'b0;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'hf, 4'hf, 2'h0, 1'b0), "resets held");
    apb(1'b1, pwrflt_pkg::REG_CTRL, 32'h7);
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h0, 2'h0, 1'b0), "running");
    rd(pwrflt_pkg::REG_STATUS, 33'h33, MS, "normal");
    se_mode <= 1'b1;
    apb(1'b1, pwrflt_pkg::REG_CTRL, 32'h6);
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h3, 2'h0, 1'b0), "single ended");
    se_mode <= 1'b0;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'h3, 4'h3, 2'h0, 1'b0), "pulldown");
    apb(1'b1, pwrflt_pkg::REG_CTRL, 32'h7);
    for (int i = 0; i < 4; i++) begin
      junction_temp_c <= (i == 0) ? 8'h7e : (i == 1) ? 8'h7d :
                         8'($urandom_range(125));
      repeat (8) @(posedge sys_clk);
      rd(pwrflt_pkg::REG_STATUS, (i == 0) ? 33'h31 : 33'h33, MS,
         "warning");
    end
    overload_det <= 2'b01;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h3, 2'h1, 1'b0), "overload");
    rd(pwrflt_pkg::REG_STATUS, 33'h36, MS, "overload flags");
    overload_det <= 2'b00;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h3, 2'h1, 1'b0), "latched");
    repeat (100) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h0, 2'h0, 1'b0), "reset clears");
    rd(pwrflt_pkg::REG_EVENTS, 33'h3, 33'h3, "events");
    apb(1'b1, pwrflt_pkg::REG_EVENTS, 32'h3);
    rd(pwrflt_pkg::REG_EVENTS, 33'h0, 33'h3, "events clear");
    common_uv <= 1'b1;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'hf, 2'h0, 1'b0), "undervoltage");
    common_uv <= 1'b0;
    repeat (100) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h0, 2'h0, 1'b0), "supply back");
    junction_temp_c <= 8'h9c;
    repeat (8) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'hf, 2'h0, 1'b1), "error");
    rd(pwrflt_pkg::REG_STATUS, 33'h34, MS, "error flags");
    junction_temp_c <= 8'h64;
    repeat (8) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'hf, 2'h0, 1'b1), "error held");
    repeat (100) @(posedge sys_clk);
    snap_dev(dw(4'h0, 4'h0, 2'h0, 1'b0), "error cleared");
    // Unmapped word must answer with an error and no data
    rd(8'h0c, 33'h1_0000_0000, {33{1'b1}}, "unmapped");
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    snap_dev(dw(4'hf, 4'hf, 2'h0, 1'b0), "second reset");
    print_verdict();
  end
endmodule
